/* File: rtl/ppc_regs.svh */
// Register offsets, field positions, masks and reset values of the port control block
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PPC_OFF_ALT 8'h00
`define PPC_OFF_PA_DATA 8'h04
`define PPC_OFF_PA_LAT 8'h08
`define PPC_OFF_PA_ANA 8'h0C
`define PPC_OFF_PB_ANA 8'h10
`define PPC_OFF_PB_WPU 8'h14
`define PPC_OFF_PB_LVL 8'h18
`define PPC_OFF_PB_RISE 8'h1C
`define PPC_OFF_PB_FALL 8'h20
`define PPC_OFF_PB_STAT 8'h24
`define PPC_OFF_CTRL 8'h28
`define PPC_OFF_PB_DATA 8'h2C

// ----------------------------------------------------------------
// Implemented bit masks
// ----------------------------------------------------------------
`define PPC_MASK_ALT_S 8'hEC
`define PPC_MASK_ALT_L 8'h8C
`define PPC_MASK_PA_LAT 8'h37
`define PPC_MASK_PA_PIN 8'h3F
`define PPC_MASK_PA_ANA 8'h17
`define PPC_MASK_PB_ANA 8'h30
`define PPC_MASK_PB_HI 8'hF0
`define PPC_MASK_CTRL 8'h01

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPC_RST_ALT 8'h00
`define PPC_RST_PA_LAT 8'h00
`define PPC_RST_PA_ANA 8'h17
`define PPC_RST_PB_ANA 8'h30
`define PPC_RST_PB_WPU 8'hF0
`define PPC_RST_ZERO 8'h00
`define PPC_RST_CTRL 8'h01

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPC_ALT_RX 7
`define PPC_ALT_SDO 6
`define PPC_ALT_SS 5
`define PPC_ALT_T1G 3
`define PPC_ALT_TX 2
`define PPC_CTRL_GDIS 0

// ----------------------------------------------------------------
// Pin positions within a port
// ----------------------------------------------------------------
`define PPC_P0 0
`define PPC_P1 1
`define PPC_P2 2
`define PPC_P3 3
`define PPC_P4 4
`define PPC_P5 5
`define PPC_P6 6
`define PPC_P7 7

`endif

/* File: rtl/ppc_pkg.sv */
// Types shared by the port control block
package ppc_pkg;

  // One port, eight pins
  typedef logic [7:0] ppc_byte_t;

  // Bus slave states, one-hot
  typedef enum logic [3:0] {
    ppc_st_idle = 4'h1,
    ppc_st_write = 4'h2,
    ppc_st_rd_wait = 4'h4,
    ppc_st_rd_done = 4'h8
  } ppc_bus_st_t;

endpackage : ppc_pkg

/* File: rtl/ppc_sync.sv */
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
module ppc_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pin side and clean side
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage, read only by the second
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
    end else begin
      meta <= async_in;
    end
  end

  // Second stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_out <= '0;
    end else begin
      sync_out <= meta;
    end
  end

endmodule : ppc_sync

/* File: rtl/ppc_port_ctrl.sv */
// Port pin control block with AHB-Lite register slave
// Function
// - Writes to port A data location land in the output latch
// - Reads of port A data location return sampled pin levels
// - Port A latch bits only at 5-4 and 2-0, drive output pins
// - Unimplemented bits ignore writes and read as zero
// - Analog-select clear hands pin to port or digital peripheral
// - Analog-select set turns off digital input buffer of pin
// - Analog-select bits B5-4 and A4, A2-0, all reset to one
// - Port B pull-up only when pin bit one and global disable zero
// - Pull-up switched off whenever pin is an output
// - Threshold bit one selects Schmitt buffer for reads and change
// - Threshold bit zero selects TTL buffer for reads and change
// - Rise enable set: rising edge sets status bit and flag
// - Fall enable set: falling edge sets status bit and flag
// - Edge enable clear: no detection for that direction
// - Latch keeps value over soft resets; others reset normally
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ppc_regs.svh"
module ppc_port_ctrl #(
  parameter bit LARGE_PKG = 1'b0
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic soft_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Port A pins
  input wire ppc_pkg::ppc_byte_t pa_in,
  output ppc_pkg::ppc_byte_t pa_out,
  output ppc_pkg::ppc_byte_t pa_oe,
  // Port B pins, two input buffers
  input wire ppc_pkg::ppc_byte_t pb_ttl_in,
  input wire ppc_pkg::ppc_byte_t pb_schmitt_in,
  output ppc_pkg::ppc_byte_t pb_out,
  output ppc_pkg::ppc_byte_t pb_oe,
  output ppc_pkg::ppc_byte_t pb_pullup,
  // Port C pins
  input wire ppc_pkg::ppc_byte_t pc_in,
  output ppc_pkg::ppc_byte_t pc_out,
  output ppc_pkg::ppc_byte_t pc_oe,
  // Pin direction, one means input
  input wire ppc_pkg::ppc_byte_t pin_direction_a,
  input wire ppc_pkg::ppc_byte_t pin_direction_b,
  input wire ppc_pkg::ppc_byte_t pin_direction_c,
  // Peripheral side
  input wire logic serial_data_out,
  input wire logic serial_transmit_line,
  output logic serial_receive_line,
  output logic slave_select_in,
  output logic timer_gate_in,
  output logic second_port_data_change_flag
);
  import ppc_pkg::*;

  localparam ppc_byte_t ALT_MASK = LARGE_PKG ? `PPC_MASK_ALT_L : `PPC_MASK_ALT_S;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  // Release reset through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  ppc_byte_t alt_pin_select_0;
  ppc_byte_t first_port_data_output_latch;
  ppc_byte_t first_port_data_analog_select;
  ppc_byte_t second_port_data_analog_select;
  ppc_byte_t second_port_data_pullup_enable;
  ppc_byte_t second_port_data_input_threshold;
  ppc_byte_t second_port_data_rise_change_enable;
  ppc_byte_t second_port_data_fall_change_enable;
  ppc_byte_t second_port_data_change_status;
  ppc_byte_t ctrl;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  ppc_bus_st_t state;
  ppc_bus_st_t next_state;
  logic [7:0] a_addr;
  logic accept;
  logic wr_en;
  ppc_byte_t wdata;
  ppc_byte_t rd_val;

  // Address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  assign accept = hsel & htrans[1] & hready;
  assign wr_en = (state == ppc_st_write);
  assign wdata = hwdata[7:0];
  assign hreadyout = (state != ppc_st_rd_wait);
  assign hresp = 1'b0;

  // Next bus state
  always_comb begin
    next_state = ppc_st_idle;
    case (state)
      ppc_st_rd_wait: next_state = ppc_st_rd_done;
      default: begin
        if (accept) begin
          next_state = hwrite ? ppc_st_write : ppc_st_rd_wait;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= ppc_st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Address phase capture
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      a_addr <= 8'h00;
    end else if (accept && state != ppc_st_rd_wait) begin
      a_addr <= haddr[7:0];
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hrdata <= 32'h0000_0000;
    end else if (state == ppc_st_rd_wait) begin
      hrdata <= {24'h00_0000, rd_val};
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  ppc_byte_t pa_sync;
  ppc_byte_t pb_ttl_sync;
  ppc_byte_t pb_st_sync;
  ppc_byte_t pc_sync;
  ppc_byte_t pa_dig;
  ppc_byte_t pb_dig;
  ppc_byte_t pb_prev;

  ppc_sync #(.WIDTH(8)) u_sync_a (
    .mclk(mclk),
    .rst_b(rst_sync_b),
    .async_in(pa_in),
    .sync_out(pa_sync)
  );

  ppc_sync #(.WIDTH(8)) u_sync_b_ttl (
    .mclk(mclk),
    .rst_b(rst_sync_b),
    .async_in(pb_ttl_in),
    .sync_out(pb_ttl_sync)
  );

  ppc_sync #(.WIDTH(8)) u_sync_b_st (
    .mclk(mclk),
    .rst_b(rst_sync_b),
    .async_in(pb_schmitt_in),
    .sync_out(pb_st_sync)
  );

  ppc_sync #(.WIDTH(8)) u_sync_c (
    .mclk(mclk),
    .rst_b(rst_sync_b),
    .async_in(pc_in),
    .sync_out(pc_sync)
  );

  // Analog pins read zero, digital pins follow the pin
  assign pa_dig = pa_sync & ~first_port_data_analog_select & `PPC_MASK_PA_PIN;
  // Buffer choice per pin, then analog gating
  assign pb_dig = ((pb_st_sync & second_port_data_input_threshold)
                  | (pb_ttl_sync & ~second_port_data_input_threshold))
                  & ~second_port_data_analog_select & `PPC_MASK_PB_HI;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (hit(a_addr, `PPC_OFF_ALT)) begin
      rd_val = alt_pin_select_0;
    end else if (hit(a_addr, `PPC_OFF_PA_DATA)) begin
      rd_val = pa_dig;
    end else if (hit(a_addr, `PPC_OFF_PA_LAT)) begin
      rd_val = first_port_data_output_latch;
    end else if (hit(a_addr, `PPC_OFF_PA_ANA)) begin
      rd_val = first_port_data_analog_select;
    end else if (hit(a_addr, `PPC_OFF_PB_ANA)) begin
      rd_val = second_port_data_analog_select;
    end else if (hit(a_addr, `PPC_OFF_PB_WPU)) begin
      rd_val = second_port_data_pullup_enable;
    end else if (hit(a_addr, `PPC_OFF_PB_LVL)) begin
      rd_val = second_port_data_input_threshold;
    end else if (hit(a_addr, `PPC_OFF_PB_RISE)) begin
      rd_val = second_port_data_rise_change_enable;
    end else if (hit(a_addr, `PPC_OFF_PB_FALL)) begin
      rd_val = second_port_data_fall_change_enable;
    end else if (hit(a_addr, `PPC_OFF_PB_STAT)) begin
      rd_val = second_port_data_change_status;
    end else if (hit(a_addr, `PPC_OFF_CTRL)) begin
      rd_val = ctrl;
    end else if (hit(a_addr, `PPC_OFF_PB_DATA)) begin
      rd_val = pb_dig;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Alternate selects; large variant also fixes bits 6 and 5 at zero
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      alt_pin_select_0 <= `PPC_RST_ALT;
    end else if (soft_rst) begin
      alt_pin_select_0 <= `PPC_RST_ALT;
    end else if (wr_en && hit(a_addr, `PPC_OFF_ALT)) begin
      alt_pin_select_0 <= wdata & ALT_MASK;
    end
  end

  // Output latch, held over soft resets
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      first_port_data_output_latch <= `PPC_RST_PA_LAT;
    end else if (wr_en && (hit(a_addr, `PPC_OFF_PA_DATA)
                 || hit(a_addr, `PPC_OFF_PA_LAT))) begin
      first_port_data_output_latch <= wdata & `PPC_MASK_PA_LAT;
    end
  end

  // Port A analog selects
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      first_port_data_analog_select <= `PPC_RST_PA_ANA;
    end else if (soft_rst) begin
      first_port_data_analog_select <= `PPC_RST_PA_ANA;
    end else if (wr_en && hit(a_addr, `PPC_OFF_PA_ANA)) begin
      first_port_data_analog_select <= wdata & `PPC_MASK_PA_ANA;
    end
  end

  // Port B analog selects
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      second_port_data_analog_select <= `PPC_RST_PB_ANA;
    end else if (soft_rst) begin
      second_port_data_analog_select <= `PPC_RST_PB_ANA;
    end else if (wr_en && hit(a_addr, `PPC_OFF_PB_ANA)) begin
      second_port_data_analog_select <= wdata & `PPC_MASK_PB_ANA;
    end
  end

  // Pull-up enables
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      second_port_data_pullup_enable <= `PPC_RST_PB_WPU;
    end else if (soft_rst) begin
      second_port_data_pullup_enable <= `PPC_RST_PB_WPU;
    end else if (wr_en && hit(a_addr, `PPC_OFF_PB_WPU)) begin
      second_port_data_pullup_enable <= wdata & `PPC_MASK_PB_HI;
    end
  end

  // Input threshold selects
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      second_port_data_input_threshold <= `PPC_RST_ZERO;
    end else if (soft_rst) begin
      second_port_data_input_threshold <= `PPC_RST_ZERO;
    end else if (wr_en && hit(a_addr, `PPC_OFF_PB_LVL)) begin
      second_port_data_input_threshold <= wdata & `PPC_MASK_PB_HI;
    end
  end

  // Edge enables
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      second_port_data_rise_change_enable <= `PPC_RST_ZERO;
      second_port_data_fall_change_enable <= `PPC_RST_ZERO;
    end else if (soft_rst) begin
      second_port_data_rise_change_enable <= `PPC_RST_ZERO;
      second_port_data_fall_change_enable <= `PPC_RST_ZERO;
    end else if (wr_en && hit(a_addr, `PPC_OFF_PB_RISE)) begin
      second_port_data_rise_change_enable <= wdata & `PPC_MASK_PB_HI;
    end else if (wr_en && hit(a_addr, `PPC_OFF_PB_FALL)) begin
      second_port_data_fall_change_enable <= wdata & `PPC_MASK_PB_HI;
    end
  end

  // Control: global pull-up disable
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl <= `PPC_RST_CTRL;
    end else if (soft_rst) begin
      ctrl <= `PPC_RST_CTRL;
    end else if (wr_en && hit(a_addr, `PPC_OFF_CTRL)) begin
      ctrl <= wdata & `PPC_MASK_CTRL;
    end
  end

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  ppc_byte_t rise_hit;
  ppc_byte_t fall_hit;
  ppc_byte_t stat_clr;

  // Previous sample of the selected buffer
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pb_prev <= 8'h00;
    end else begin
      pb_prev <= pb_dig;
    end
  end

  assign rise_hit = pb_dig & ~pb_prev & second_port_data_rise_change_enable;
  assign fall_hit = ~pb_dig & pb_prev & second_port_data_fall_change_enable;
  assign stat_clr = (wr_en && hit(a_addr, `PPC_OFF_PB_STAT)) ? wdata : 8'h00;

  // Sticky status; a new edge beats a write-one clear
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      second_port_data_change_status <= `PPC_RST_ZERO;
    end else if (soft_rst) begin
      second_port_data_change_status <= `PPC_RST_ZERO;
    end else begin
      second_port_data_change_status <= ((second_port_data_change_status & ~stat_clr) | rise_hit | fall_hit)
                             & `PPC_MASK_PB_HI;
    end
  end

  // Flag while any status bit stands
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      second_port_data_change_flag <= 1'b0;
    end else begin
      second_port_data_change_flag <= |second_port_data_change_status;
    end
  end

  // ----------------------------------------------------------------
  // Pull-ups
  // ----------------------------------------------------------------
  // Per-pin enable, global disable, and off for outputs
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pb_pullup <= 8'h00;
    end else begin
      pb_pullup <= second_port_data_pullup_enable & {8{~ctrl[`PPC_CTRL_GDIS]}}
                   & pin_direction_b;
    end
  end

  // ----------------------------------------------------------------
  // Alternate pin steering and pin drive
  // ----------------------------------------------------------------
  logic sel_rx;
  logic sel_sdo;
  logic sel_ss;
  logic sel_t1g;
  logic sel_tx;

  assign sel_rx = alt_pin_select_0[`PPC_ALT_RX];
  assign sel_sdo = alt_pin_select_0[`PPC_ALT_SDO];
  assign sel_ss = alt_pin_select_0[`PPC_ALT_SS];
  assign sel_t1g = alt_pin_select_0[`PPC_ALT_T1G];
  assign sel_tx = alt_pin_select_0[`PPC_ALT_TX];

  // Peripheral inputs picked from default or alternate pin
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      serial_receive_line <= 1'b0;
      slave_select_in <= 1'b0;
      timer_gate_in <= 1'b0;
    end else begin
      if (LARGE_PKG) begin
        serial_receive_line <= sel_rx ? pc_sync[`PPC_P5] : pb_dig[`PPC_P5];
        slave_select_in <= pc_sync[`PPC_P6];
      end else begin
        serial_receive_line <= sel_rx ? pa_dig[`PPC_P1] : pc_sync[`PPC_P5];
        slave_select_in <= sel_ss ? pa_dig[`PPC_P3] : pc_sync[`PPC_P3];
      end
      timer_gate_in <= sel_t1g ? pa_dig[`PPC_P3] : pa_dig[`PPC_P4];
    end
  end

  // Pin output values, port A latch and ports B and C low, unless a peripheral owns the pin
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pa_out <= 8'h00;
      pb_out <= 8'h00;
      pc_out <= 8'h00;
    end else begin
      pa_out <= first_port_data_output_latch;
      pb_out <= 8'h00;
      pc_out <= 8'h00;
      if (LARGE_PKG) begin
        pc_out[`PPC_P7] <= serial_data_out;
        if (sel_tx) begin
          pc_out[`PPC_P4] <= serial_transmit_line;
        end else begin
          pb_out[`PPC_P7] <= serial_transmit_line;
        end
      end else begin
        if (sel_sdo) begin
          pa_out[`PPC_P4] <= serial_data_out;
        end else begin
          pc_out[`PPC_P2] <= serial_data_out;
        end
        if (sel_tx) begin
          pa_out[`PPC_P0] <= serial_transmit_line;
        end else begin
          pc_out[`PPC_P4] <= serial_transmit_line;
        end
      end
    end
  end

  // Drive enables follow direction; analog pins expect input direction
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pa_oe <= 8'h00;
      pb_oe <= 8'h00;
      pc_oe <= 8'h00;
    end else begin
      pa_oe <= ~pin_direction_a & `PPC_MASK_PA_PIN;
      pb_oe <= ~pin_direction_b & `PPC_MASK_PB_HI;
      pc_oe <= ~pin_direction_c;
    end
  end

endmodule : ppc_port_ctrl

/* File: tb/ppc_checker.sv */
// Assertion checker for the port control block
`timescale 1ns/1ps
module ppc_checker #(
  parameter bit LARGE_PKG = 1'b0
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic soft_rst,
  // Register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pins
  input wire ppc_pkg::ppc_byte_t pa_oe,
  input wire ppc_pkg::ppc_byte_t pb_oe,
  input wire ppc_pkg::ppc_byte_t pb_pullup
);
  import ppc_pkg::*;
  // ----------------------------------------------------------------
  // Bus timing and pin safety
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Transfer accepted at this edge
  wire taken = hsel && htrans[1] && hready;
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not exactly one cycle");
  write_fast_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  rdata_hold_a: assert property ($past(hreadyout) && !$past(soft_rst) |-> $stable(hrdata))
    else $error("read data moved outside a read");
  upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  pull_drive_a: assert property ((pb_pullup & pb_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  pull_low_a: assert property (pb_pullup[3:0] == 4'h0)
    else $error("pull-up on a pin without one");
  pa_gap_a: assert property (pa_oe[7:6] == 2'h0)
    else $error("missing port A pin driven");
  soft_pull_a: assert property (soft_rst |-> ##2 (pb_pullup == 8'h00))
    else $error("pull-ups stay on after soft reset");
endmodule : ppc_checker

bind ppc_port_ctrl ppc_checker #(.LARGE_PKG(LARGE_PKG)) chk_i (.mclk(mclk), .rst_b(rst_b),
  .soft_rst(soft_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pa_oe(pa_oe), .pb_oe(pb_oe),
  .pb_pullup(pb_pullup));

/* File: tb/ppc_pin_model.sv */
// Model of the circuitry outside the port pins
`timescale 1ns/1ps
module ppc_pin_model (
  // Device drive
  input wire ppc_pkg::ppc_byte_t pa_out,
  input wire ppc_pkg::ppc_byte_t pa_oe,
  input wire ppc_pkg::ppc_byte_t pb_out,
  input wire ppc_pkg::ppc_byte_t pb_oe,
  input wire ppc_pkg::ppc_byte_t pc_out,
  input wire ppc_pkg::ppc_byte_t pc_oe,
  // Outside sources, mid marks a level between the two thresholds
  input wire ppc_pkg::ppc_byte_t ext_a,
  input wire ppc_pkg::ppc_byte_t ext_b,
  input wire ppc_pkg::ppc_byte_t ext_c,
  input wire ppc_pkg::ppc_byte_t mid_b,
  // Levels seen by the device
  output ppc_pkg::ppc_byte_t pa_in,
  output ppc_pkg::ppc_byte_t pb_ttl_in,
  output ppc_pkg::ppc_byte_t pb_schmitt_in,
  output ppc_pkg::ppc_byte_t pc_in
);
  import ppc_pkg::*;
  // Driven pins show the device, the rest the outside source
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
  // Mid level reads high on TTL, low on Schmitt
  assign pb_ttl_in = (pb_oe & pb_out) | (~pb_oe & (ext_b | mid_b));
  assign pb_schmitt_in = (pb_oe & pb_out) | (~pb_oe & ext_b & ~mid_b);
endmodule : ppc_pin_model

/* File: tb/tb.sv */
// Self-checking bench for the port control block
`timescale 1ns/1ps
module tb;
  import ppc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0, rst_b = 1'b0, soft_rst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic serial_data_out = 1'b0, serial_transmit_line = 1'b0;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  ppc_byte_t dir_a = 8'hFF, dir_b = 8'hFF, dir_c = 8'hFF;
  ppc_byte_t ext_a = 8'h00, ext_b = 8'h00, ext_c = 8'h00, mid_b = 8'h00;
  wire logic hrdy, hresp, serial_receive_line, timer_gate_in, second_port_data_change_flag;
  wire logic slave_select_in;
  wire logic [31:0] hrdata;
  wire ppc_byte_t pa_in, pa_out, pa_oe, pb_ttl_in, pb_schmitt_in, pb_out, pb_oe;
  wire ppc_byte_t pb_pullup, pc_in, pc_out, pc_oe;
  // Peripheral steering seen at once
  wire logic [7:0] steer = {1'b0, slave_select_in, pa_out[4], serial_receive_line,
    timer_gate_in, pa_out[0], pc_out[4], pc_out[2]};
  int mismatches = 0, samples_checked = 0;
  // Register table: offset, reset value, value read back after writing all ones
  logic [7:0] offs [10] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h17, 8'h30, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] msk [10] = '{8'hEC, 8'h37, 8'h17, 8'h30, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'h00, 8'h01};

  always #10 mclk = ~mclk;

  ppc_port_ctrl DUT (.mclk, .rst_b, .soft_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata, .pa_in, .pa_out, .pa_oe,
    .pb_ttl_in, .pb_schmitt_in, .pb_out, .pb_oe, .pb_pullup, .pc_in, .pc_out, .pc_oe,
    .pin_direction_a(dir_a), .pin_direction_b(dir_b), .pin_direction_c(dir_c),
    .serial_data_out, .serial_transmit_line, .serial_receive_line, .slave_select_in,
    .timer_gate_in, .second_port_data_change_flag);

  ppc_pin_model pins (.pa_out, .pa_oe, .pb_out, .pb_oe, .pc_out, .pc_oe, .ext_a, .ext_b,
    .ext_c, .mid_b, .pa_in, .pb_ttl_in, .pb_schmitt_in, .pc_in);

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task test_done;
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready is stable from the falling edge to the next rising edge
  task rdy;
    int n;
    n = 0;
    @(negedge mclk);
    while (hrdy !== 1'b1 && n < 20) begin
      n++;
      @(negedge mclk);
    end
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
  endtask : rdy

  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    rdy();
    @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    rdy();
    @(posedge mclk);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd[7:0], exp);
  endtask : rc

  // Waits cover the two-flop pin synchroniser and output flops
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    cyc(3);
    for (int i = 0; i < 10; i++) rc(offs[i], rstv[i]);
    for (int i = 0; i < 10; i++) begin
      wr(offs[i], 8'hFF);
      rc(offs[i], msk[i]);
      wr(offs[i], 8'h00);
    end
    wr(8'h3C, 8'hFF);
    rc(8'h3C, 8'h00);
    // Port A data goes to the latch, reads see pins
    dir_a <= 8'h00;
    wr(8'h04, 8'hFF);
    rc(8'h08, 8'h37);
    cyc(2);
    chk(pa_out, 8'h37);
    chk(pa_oe, 8'h3F);
    rc(8'h04, 8'h37);
    dir_a <= 8'hFF;
    ext_a <= 8'h2A;
    wr(8'h0C, 8'h17);
    cyc(3);
    rc(8'h04, 8'h28);
    wr(8'h0C, 8'h00);
    rc(8'h04, 8'h2A);
    // Alternate pin steering, default then alternate
    wr(8'h04, 8'h00);
    dir_c <= 8'h20;
    ext_c <= 8'h20;
    ext_a <= 8'h28;
    serial_transmit_line <= 1'b1;
    serial_data_out <= 1'b1;
    cyc(4);
    chk(steer, 8'h13);
    wr(8'h00, 8'hEC);
    cyc(4);
    chk(steer, 8'h6C);
    wr(8'h00, 8'h00);
    // Pull-ups: global disable, per pin, outputs
    dir_b <= 8'hF0;
    wr(8'h14, 8'hF0);
    wr(8'h28, 8'h01);
    cyc(2);
    chk(pb_pullup, 8'h00);
    wr(8'h28, 8'h00);
    cyc(2);
    chk(pb_pullup, 8'hF0);
    dir_b <= 8'h70;
    cyc(2);
    chk(pb_pullup, 8'h70);
    dir_b <= 8'hF0;
    // Input buffer choice on a mid level
    mid_b <= 8'hC0;
    cyc(4);
    rc(8'h2C, 8'hC0);
    wr(8'h18, 8'hF0);
    rc(8'h2C, 8'h00);
    wr(8'h18, 8'h00);
    mid_b <= 8'h00;
    cyc(4);
    wr(8'h24, 8'hF0);
    // Edge detection, one direction enabled per pin
    wr(8'h1C, 8'h10);
    wr(8'h20, 8'h20);
    ext_b <= 8'h30;
    cyc(6);
    rc(8'h24, 8'h10);
    chk({7'h00, second_port_data_change_flag}, 8'h01);
    wr(8'h24, 8'hF0);
    cyc(2);
    chk({7'h00, second_port_data_change_flag}, 8'h00);
    ext_b <= 8'h00;
    cyc(6);
    rc(8'h24, 8'h20);
    wr(8'h24, 8'hF0);
    // Soft reset keeps the latch, restores the rest
    wr(8'h08, 8'h25);
    wr(8'h14, 8'h50);
    soft_rst <= 1'b1;
    cyc(1);
    soft_rst <= 1'b0;
    cyc(1);
    rc(8'h08, 8'h25);
    rc(8'h14, 8'hF0);
    rc(8'h28, 8'h01);
    test_done();
  end
endmodule : tb
